// *** common/servo_bus_if.sv ***
/*
 * 8-bit microprocessor data bus between the bus master and the servo loop.
 * assumes pullups on the data lines: an undriven bus reads all ones.
 */
`timescale 1ns/10ps
interface servo_bus_if;
    import servo_loop_pkg::*;

    logic cs_n;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [BYTE_W-1:0] host_data;
    logic host_data_oe;
    logic [BYTE_W-1:0] dev_data;
    logic dev_data_oe;
    logic bus_disconnect_n;
    logic [BYTE_W-1:0] bus_level;

    // wire resolution from the enables
    assign bus_level = host_data_oe ? host_data : (dev_data_oe ? dev_data : BUS_IDLE_LEVEL);

    modport device (
        input cs_n,
        input addr,
        input wr,
        input rd,
        input bus_level,
        input bus_disconnect_n,
        output dev_data,
        output dev_data_oe
    );

    modport host (
        output cs_n,
        output addr,
        output wr,
        output rd,
        output host_data,
        output host_data_oe,
        output bus_disconnect_n,
        input bus_level
    );

endinterface : servo_bus_if

// *** common/servo_loop_pkg.sv ***
/*
 * constants shared by the servo counter device end and the bus master end.
 * assumes a 100 MHz system clock common to both ends.
 */
package servo_loop_pkg;

    // counter geometry
    localparam int COUNT_W = 16;
    localparam int STAGE_W = 4;
    localparam int STAGES = 4;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 4;
    localparam logic [STAGE_W-1:0] STAGE_MAX = 4'hF;
    localparam logic [STAGE_W-1:0] STAGE_MIN = 4'h0;
    localparam logic [STAGE_W-1:0] STAGE_STEP = 4'h1;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] BUFFER_RESET = 16'h0000;

    //////////////////////////////////////////////////////////////////////////
    // count clock timing
    localparam real CLK_FREQ_MHZ = 100.0;
    localparam real COUNT_PERIOD_US = 1.5;
    localparam int DIV_COUNT = int'(COUNT_PERIOD_US * CLK_FREQ_MHZ);
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_COUNT - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV_COUNT / 2);
    localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;

    //////////////////////////////////////////////////////////////////////////
    // bus address map: A3 = 0 selects the dac latches, A2..A0 the strobes
    localparam int ADDR_SPACE_BIT = 3;
    localparam int ADDR_LOAD_BIT = 2;
    localparam int ADDR_UPPER_BIT = 1;
    localparam int ADDR_LOWER_BIT = 0;
    localparam logic [ADDR_W-1:0] ADDR_DAC_LOWER = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_DAC_UPPER = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_DAC_LOAD = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 4'hA;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 4'hB;
    localparam logic [ADDR_W-1:0] ADDR_IDLE = 4'h0;

    // control byte fields
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_GATE_N_BIT = 1;
    localparam int CTRL_ENDPOINT_BIT = 2;
    localparam logic [BYTE_W-1:0] CTRL_HOLD_MASK = 8'h01;
    localparam logic [BYTE_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BYTE_W-1:0] BUS_IDLE_LEVEL = 8'hFF;

    // host commands
    typedef enum logic [1:0] {
        CMD_DAC_WRITE = 2'h0,
        CMD_CTRL_WRITE = 2'h1,
        CMD_COUNT_READ = 2'h2
    } cmd_kind_t;

endpackage : servo_loop_pkg

// *** src/servo_bus_master.sv ***
/*
 * bus master end: turns user commands into 8-bit bus accesses to the servo
 * loop (dac code write, control write, consistent two-byte count read).
 * assumes the servo loop answers a read one clk after the access cycle.
 */
`timescale 1ns/10ps
module servo_bus_master
    import servo_loop_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    servo_bus_if.host bus,
    input wire logic cmd_valid,
    input wire cmd_kind_t cmd_kind,
    input wire logic [COUNT_W-1:0] cmd_data,
    input wire logic disconnect_request,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [COUNT_W-1:0] rsp_count
);

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_DRIVE = 3'b010,
        H_WAIT = 3'b100
    } host_state_t;

    typedef struct packed {
        host_state_t state;
        logic [1:0] step;
        cmd_kind_t kind;
        logic [COUNT_W-1:0] data;
        logic [BYTE_W-1:0] shadow_ctrl;
        logic cs_n;
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [BYTE_W-1:0] host_data;
        logic host_data_oe;
        logic disc_n;
        logic cmd_ready;
        logic rsp_valid;
        logic [COUNT_W-1:0] rsp_count;
    } host_regs_t;

    localparam host_regs_t HOST_RESET = '{
        state: H_IDLE, step: 2'h0, kind: CMD_DAC_WRITE, data: COUNT_RESET,
        shadow_ctrl: CTRL_RESET, cs_n: 1'b1, addr: ADDR_IDLE, wr: 1'b0, rd: 1'b0,
        host_data: BYTE_ZERO, host_data_oe: 1'b0, disc_n: 1'b1, cmd_ready: 1'b0,
        rsp_valid: 1'b0, rsp_count: COUNT_RESET
    };

    host_regs_t st;
    host_regs_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // access sequences: {read, addr, byte}

    function automatic logic [ADDR_W+BYTE_W:0] op_for(
        input cmd_kind_t kind,
        input logic [1:0] step,
        input logic [COUNT_W-1:0] data,
        input logic [BYTE_W-1:0] shadow
    );
        logic [ADDR_W+BYTE_W:0] op;
        op = {1'b0, ADDR_CTRL, data[BYTE_W-1:0]};
        case (kind)
            CMD_DAC_WRITE: begin
                case (step)
                    2'h0: op = {1'b0, ADDR_DAC_LOWER, data[BYTE_W-1:0]};
                    2'h1: op = {1'b0, ADDR_DAC_UPPER, data[COUNT_W-1:BYTE_W]};
                    default: op = {1'b0, ADDR_DAC_LOAD, BYTE_ZERO};
                endcase
            end
            CMD_COUNT_READ: begin
                case (step)
                    2'h0: op = {1'b0, ADDR_CTRL, shadow | CTRL_HOLD_MASK};
                    2'h1: op = {1'b1, ADDR_COUNT_LO, BYTE_ZERO};
                    2'h2: op = {1'b1, ADDR_COUNT_HI, BYTE_ZERO};
                    default: op = {1'b0, ADDR_CTRL, shadow};
                endcase
            end
            default: op = {1'b0, ADDR_CTRL, data[BYTE_W-1:0]};
        endcase
        return op;
    endfunction : op_for

    function automatic logic [1:0] last_step(input cmd_kind_t kind);
        case (kind)
            CMD_DAC_WRITE: return 2'h2;
            CMD_COUNT_READ: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction : last_step

    ////////////////////////////////////////////////////////////////////////////

    logic [ADDR_W+BYTE_W:0] op;
    logic [1:0] op_step;
    logic start_op;

    always_comb begin
        next_st = st;
        next_st.rsp_valid = 1'b0;
        next_st.disc_n = ~disconnect_request;
        start_op = 1'b0;
        op_step = 2'h0;
        case (st.state)
            H_IDLE: begin
                next_st.cmd_ready = 1'b1;
                if (cmd_valid && st.cmd_ready) begin
                    next_st.kind = cmd_kind;
                    next_st.data = cmd_data;
                    next_st.cmd_ready = 1'b0;
                    start_op = 1'b1;
                    if (cmd_kind == CMD_CTRL_WRITE) begin
                        next_st.shadow_ctrl = cmd_data[BYTE_W-1:0];
                    end
                end
            end
            H_DRIVE: begin
                next_st.cs_n = 1'b1;
                next_st.wr = 1'b0;
                next_st.rd = 1'b0;
                next_st.host_data_oe = 1'b0;
                next_st.state = H_WAIT;
            end
            H_WAIT: begin
                if (st.kind == CMD_COUNT_READ && st.step == 2'h1) begin
                    next_st.rsp_count[BYTE_W-1:0] = bus.bus_level;
                end
                if (st.kind == CMD_COUNT_READ && st.step == 2'h2) begin
                    next_st.rsp_count[COUNT_W-1:BYTE_W] = bus.bus_level;
                end
                if (st.step == last_step(st.kind)) begin
                    next_st.state = H_IDLE;
                    next_st.cmd_ready = 1'b1;
                    next_st.rsp_valid = (st.kind == CMD_COUNT_READ);
                end else begin
                    start_op = 1'b1;
                    op_step = st.step + 2'h1;
                end
            end
            default: next_st = HOST_RESET;
        endcase
        op = op_for(next_st.kind, op_step, next_st.data, next_st.shadow_ctrl);
        if (start_op) begin
            next_st.state = H_DRIVE;
            next_st.step = op_step;
            next_st.cs_n = 1'b0;
            next_st.addr = op[ADDR_W+BYTE_W-1:BYTE_W];
            next_st.rd = op[ADDR_W+BYTE_W];
            next_st.wr = ~op[ADDR_W+BYTE_W];
            next_st.host_data = op[BYTE_W-1:0];
            next_st.host_data_oe = ~op[ADDR_W+BYTE_W];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= HOST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign bus.cs_n = st.cs_n;
    assign bus.addr = st.addr;
    assign bus.wr = st.wr;
    assign bus.rd = st.rd;
    assign bus.host_data = st.host_data;
    assign bus.host_data_oe = st.host_data_oe;
    assign bus.bus_disconnect_n = st.disc_n;
    assign cmd_ready = st.cmd_ready;
    assign rsp_valid = st.rsp_valid;
    assign rsp_count = st.rsp_count;

endmodule : servo_bus_master

// *** src/servo_counter_loop.sv ***
/*
 * digital part of a tracking servo loop: count clock divider, 16-bit
 * up/down counter in four 4-bit stages, dac input latches, bus decode
 * and count readback through the bus switch.
 * assumes the comparator decision is synchronous to clk and that the
 * bus master holds each access for one clk cycle.
 */
// Overview of operation
// - each count clock steps toward comparator decision
// - comparator high counts up, low counts down
// - exactly one lsb per count clock, dithers
// - sixteen bits as four cascaded 4-bit stages
// - count clock 667 kHz, 1.5 us period
// - hold enable freezes counter value indefinitely
// - inactive gate releases counter from dac lines
// - basic mode wraps at both scale ends
// - endpoint mode: xnor terminal carry, toggle inside
// - bus master writes code overriding counter
// - open-loop: latches keep bus written data
// - master reads count as two bytes
// - long reads halt tracking during read
// - disconnect low isolates bus from loop
// - count is straight binary of both voltages
// - byte loads fill first, load moves second
`timescale 1ns/10ps
module servo_counter_loop
    import servo_loop_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    servo_bus_if.device bus,
    input wire logic comparator_high,
    output logic [COUNT_W-1:0] dac_code,
    output logic [COUNT_W-1:0] count_value,
    output logic count_clock,
    output logic counter_drive
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic count_clock;
        logic [COUNT_W-1:0] count;
        logic [COUNT_W-1:0] first_buf;
        logic [COUNT_W-1:0] second_buf;
        logic count_hold_enable;
        logic counter_gate_n;
        logic endpoint_mode;
        logic [BYTE_W-1:0] rd_data;
        logic rd_oe;
        logic [COUNT_W-1:0] dac_code;
        logic counter_drive;
    } loop_state_t;

    localparam loop_state_t LOOP_RESET = '{
        div: DIV_ZERO,
        count_clock: 1'b0,
        count: COUNT_RESET,
        first_buf: BUFFER_RESET,
        second_buf: BUFFER_RESET,
        count_hold_enable: CTRL_RESET[CTRL_HOLD_BIT],
        counter_gate_n: CTRL_RESET[CTRL_GATE_N_BIT],
        endpoint_mode: CTRL_RESET[CTRL_ENDPOINT_BIT],
        rd_data: BYTE_ZERO,
        rd_oe: 1'b0,
        dac_code: COUNT_RESET,
        counter_drive: ~CTRL_RESET[CTRL_GATE_N_BIT]
    };

    loop_state_t st;
    loop_state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // counter stages

    // one count of the cascade; the top bit is the carry out of the last
    // stage, i.e. the terminal count in the chosen direction
    function automatic logic [COUNT_W:0] count_step(
        input logic [COUNT_W-1:0] value,
        input logic up
    );
        logic carry;
        logic [STAGE_W-1:0] nib;
        logic [COUNT_W-1:0] res;
        carry = 1'b1;
        res = value;
        for (int s = 0; s < STAGES; s++) begin
            nib = value[s*STAGE_W +: STAGE_W];
            if (carry) begin
                res[s*STAGE_W +: STAGE_W] = up ? nib + STAGE_STEP : nib - STAGE_STEP;
            end
            carry = carry & (up ? (nib == STAGE_MAX) : (nib == STAGE_MIN));
        end
        return {carry, res};
    endfunction : count_step

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic tick;
    logic [COUNT_W:0] probe;
    logic terminal_carry_out_n;
    logic count_up;
    logic [COUNT_W:0] stepped;
    logic selected;
    logic wr_en;
    logic rd_en;
    logic lower_byte_load;
    logic upper_byte_load;
    logic dac_load_strobe;
    logic dac_op_valid;

    always_comb begin
        next_st = st;

        // count clock divider; a coarse square is driven out for observation
        tick = (st.div == DIV_LAST);
        next_st.div = tick ? DIV_ZERO : st.div + DIV_ONE;
        next_st.count_clock = (next_st.div < DIV_HALF);

        // direction: raw comparator, or xnor with active-low terminal carry
        probe = count_step(st.count, comparator_high);
        terminal_carry_out_n = ~probe[COUNT_W];
        if (st.endpoint_mode) begin
            count_up = ~(terminal_carry_out_n ^ comparator_high);
        end else begin
            count_up = comparator_high;
        end
        stepped = count_step(st.count, count_up);

        // holding stops counting but leaves the latches and bus alone
        if (tick && !st.count_hold_enable) begin
            next_st.count = stepped[COUNT_W-1:0];
        end

        // bus decode; with the switch inhibited nothing on the bus reaches
        // the loop and nothing is driven back
        selected = ~bus.cs_n & bus.bus_disconnect_n;
        wr_en = selected & bus.wr;
        rd_en = selected & bus.rd;
        lower_byte_load = wr_en & ~bus.addr[ADDR_SPACE_BIT] & bus.addr[ADDR_LOWER_BIT];
        upper_byte_load = wr_en & ~bus.addr[ADDR_SPACE_BIT] & bus.addr[ADDR_UPPER_BIT];
        dac_load_strobe = wr_en & ~bus.addr[ADDR_SPACE_BIT] & bus.addr[ADDR_LOAD_BIT];
        // lower+upper without load, and lower+load without upper, are invalid
        dac_op_valid = ~((lower_byte_load & upper_byte_load & ~dac_load_strobe)
                       | (lower_byte_load & ~upper_byte_load & dac_load_strobe));

        // level latches: a load in the same cycle passes straight through
        if (dac_op_valid) begin
            if (lower_byte_load) begin
                next_st.first_buf[BYTE_W-1:0] = bus.bus_level;
            end
            if (upper_byte_load) begin
                next_st.first_buf[COUNT_W-1:BYTE_W] = bus.bus_level;
            end
            if (dac_load_strobe) begin
                next_st.second_buf = next_st.first_buf;
            end
        end

        if (wr_en && bus.addr == ADDR_CTRL) begin
            next_st.count_hold_enable = bus.bus_level[CTRL_HOLD_BIT];
            next_st.counter_gate_n = bus.bus_level[CTRL_GATE_N_BIT];
            next_st.endpoint_mode = bus.bus_level[CTRL_ENDPOINT_BIT];
        end

        // count readback, one byte per access
        next_st.rd_oe = rd_en & ((bus.addr == ADDR_COUNT_LO) | (bus.addr == ADDR_COUNT_HI));
        if (bus.addr == ADDR_COUNT_HI) begin
            next_st.rd_data = st.count[COUNT_W-1:BYTE_W];
        end else begin
            next_st.rd_data = st.count[BYTE_W-1:0];
        end

        // dac inputs: counter while gated on, else the held bus code
        if (next_st.counter_gate_n) begin
            next_st.dac_code = next_st.second_buf;
        end else begin
            next_st.dac_code = next_st.count;
        end

        // registered copy of the gate so the pin comes straight from a flop
        next_st.counter_drive = ~next_st.counter_gate_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= LOOP_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign dac_code = st.dac_code;
    assign count_value = st.count;
    assign count_clock = st.count_clock;
    assign counter_drive = st.counter_drive;
    assign bus.dev_data = st.rd_data;
    assign bus.dev_data_oe = st.rd_oe;

endmodule : servo_counter_loop

// *** verification/servo_loop_props.sv ***
/*
 * concurrent checks on the servo bus and the counter loop outputs.
 * assumes one clk domain and the signals of servo_bus_if as plain inputs.
 */
`timescale 1ns/10ps
module servo_loop_props
    import servo_loop_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [BYTE_W-1:0] bus_level,
    input wire logic dev_data_oe,
    input wire logic [BYTE_W-1:0] dev_data,
    input wire logic bus_disconnect_n,
    input wire logic [COUNT_W-1:0] count_value,
    input wire logic [COUNT_W-1:0] dac_code,
    input wire logic counter_drive
);
    logic hold_q;
    int gap;
    wire logic sel = !cs_n && bus_disconnect_n;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_rd(a);
        sel && rd && addr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    // mirror of the hold bit and cycles since the last step
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 1'b0;
            gap <= 0;
        end else begin
            if (sel && wr && addr == ADDR_CTRL) begin
                hold_q <= bus_level[CTRL_HOLD_BIT];
            end
            gap <= $changed(count_value) ? 1 : gap + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_read_low: assert property (s_rd(ADDR_COUNT_LO) |=>
        dev_data_oe && dev_data == $past(count_value[7:0]))
        else $error("low count byte not answered");
    chk_read_high: assert property (s_rd(ADDR_COUNT_HI) |=>
        dev_data_oe && dev_data == $past(count_value[15:8]))
        else $error("high count byte not answered");
    chk_no_stray_drive: assert property (dev_data_oe |->
        $past(sel && rd && (addr == ADDR_COUNT_LO || addr == ADDR_COUNT_HI)))
        else $error("device drove bus without a read");
    chk_isolate_bus: assert property (!bus_disconnect_n |=> !dev_data_oe)
        else $error("device drove bus while disconnected");
    chk_step_one: assert property ($changed(count_value) |->
        COUNT_W'(count_value - $past(count_value)) inside {16'h0001, 16'hFFFF})
        else $error("count moved by more than one");
    chk_step_spacing: assert property ($changed(count_value) |->
        gap % DIV_COUNT == 0)
        else $error("count stepped off the count clock");
    chk_hold_freeze: assert property (hold_q && $past(hold_q) |->
        $stable(count_value))
        else $error("count moved while held");
    chk_gate_dac: assert property (counter_drive && $past(counter_drive) |->
        dac_code == count_value)
        else $error("dac lines differ from count while gated on");
endmodule : servo_loop_props

// *** verification/tb_tracking_servo_counter_loop.sv ***
/*
 * testbench joining the servo loop and its bus master through servo_bus_if.
 * assumes both ends share clk and reset_n; no far-side model is needed.
 */
`timescale 1ns/10ps
module tb_tracking_servo_counter_loop
    import servo_loop_pkg::*;
;
    typedef struct {logic [15:0] code; logic [7:0] lo; logic [7:0] hi;} row_t;
    logic clk, reset_n, comparator_high, cmd_valid, disconnect_request;
    logic cmd_ready, rsp_valid, counter_drive, count_clock;
    cmd_kind_t cmd_kind;
    logic [COUNT_W-1:0] cmd_data, rsp_count, dac_code, count_value;
    int n_mismatch, samples_checked;
    logic [11:0] wq[$];
    row_t rows[4] = '{'{16'h0000, 8'h00, 8'h00}, '{16'hFFFF, 8'hFF, 8'hFF},
        '{16'h1234, 8'h34, 8'h12}, '{16'h8001, 8'h01, 8'h80}};

    servo_bus_if bus();
    servo_counter_loop servo_counter_loop_inst(.clk(clk), .reset_n(reset_n), .bus(bus),
        .comparator_high(comparator_high), .dac_code(dac_code), .count_value(count_value),
        .count_clock(count_clock), .counter_drive(counter_drive));
    servo_bus_master servo_bus_master_inst(.clk(clk), .reset_n(reset_n), .bus(bus),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_data(cmd_data),
        .disconnect_request(disconnect_request), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_count(rsp_count));
    servo_loop_props servo_loop_props_inst(.clk(clk), .reset_n(reset_n), .cs_n(bus.cs_n),
        .addr(bus.addr), .wr(bus.wr), .rd(bus.rd), .bus_level(bus.bus_level),
        .dev_data_oe(bus.dev_data_oe), .dev_data(bus.dev_data),
        .bus_disconnect_n(bus.bus_disconnect_n), .count_value(count_value),
        .dac_code(dac_code), .counter_drive(counter_drive));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // log of writes as they appear on the wire
    always @(posedge clk) begin
        if (!bus.cs_n && bus.wr && bus.bus_disconnect_n) wq.push_back({bus.addr, bus.bus_level});
    end

    ////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task timeout;
        check("wait", 16'h0001, 16'h0000);
        tally_and_finish();
    endtask : timeout

    // entered just after an edge at which cmd_ready was high
    task cmd(input cmd_kind_t k, input logic [15:0] d);
        int i;
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        if (i == 20) timeout();
        if (k == CMD_COUNT_READ) check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    endtask : cmd

    task wait_step;
        logic [15:0] c;
        int i;
        c = count_value;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (count_value !== c) break;
        end
        if (i == 400) timeout();
    endtask : wait_step

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        comparator_high = 1'b0;
        cmd_valid = 1'b0;
        cmd_kind = CMD_DAC_WRITE;
        cmd_data = 16'h0000;
        disconnect_request = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("count", COUNT_RESET, count_value);
        check("counter_drive", 16'h0001, {15'h0000, counter_drive});
        $display("end of test reset");
        wait_step();
        check("wrap down", 16'hFFFF, count_value);
        // the step lands as the divider restarts, in the high half of the count clock
        check("count_clock high", 16'h0001, {15'h0000, count_clock});
        comparator_high <= 1'b1;
        repeat (DIV_COUNT / 2) @(posedge clk);
        check("count_clock low", 16'h0000, {15'h0000, count_clock});
        wait_step();
        check("wrap up", 16'h0000, count_value);
        repeat (3 * DIV_COUNT) @(posedge clk);
        check("three steps up", 16'h0003, count_value);
        // the master holds tracking so both bytes come from one count
        cmd(CMD_COUNT_READ, 16'h0000);
        check("read count", 16'h0003, rsp_count);
        $display("end of test tracking");
        cmd(CMD_CTRL_WRITE, 16'h0001);
        repeat (2 * DIV_COUNT) @(posedge clk);
        check("held count", 16'h0003, count_value);
        $display("end of test hold");
        comparator_high <= 1'b0;
        cmd(CMD_CTRL_WRITE, 16'h0004);
        repeat (3) wait_step();
        check("down to zero", 16'h0000, count_value);
        wait_step();
        check("endpoint toggle in", 16'h0001, count_value);
        wait_step();
        check("endpoint toggle out", 16'h0000, count_value);
        cmd(CMD_CTRL_WRITE, 16'h0000);
        wait_step();
        check("wrap to top", 16'hFFFF, count_value);
        comparator_high <= 1'b1;
        cmd(CMD_CTRL_WRITE, 16'h0004);
        wait_step();
        check("top endpoint", 16'hFFFE, count_value);
        $display("end of test endpoint");
        cmd(CMD_CTRL_WRITE, 16'h0003);
        check("gate off", 16'h0000, {15'h0000, counter_drive});
        foreach (rows[i]) begin
            wq.delete();
            cmd(CMD_DAC_WRITE, rows[i].code);
            @(posedge clk);
            check("dac_code", rows[i].code, dac_code);
            check("write count", 16'h0003, 16'(wq.size()));
            check("lower write", {4'h0, ADDR_DAC_LOWER, rows[i].lo}, {4'h0, wq[0]});
            check("upper write", {4'h0, ADDR_DAC_UPPER, rows[i].hi}, {4'h0, wq[1]});
            check("load addr", {12'h000, ADDR_DAC_LOAD}, {12'h000, wq[2][11:8]});
        end
        $display("end of test open loop");
        disconnect_request <= 1'b1;
        @(posedge clk);
        cmd(CMD_DAC_WRITE, 16'h5A5A);
        @(posedge clk);
        check("isolated dac_code", rows[3].code, dac_code);
        cmd(CMD_COUNT_READ, 16'h0000);
        check("isolated read", 16'hFFFF, rsp_count);
        $display("end of test disconnect");
        // reset in mid-run: both ends must return to tracking from zero
        reset_n <= 1'b0;
        disconnect_request <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset count", COUNT_RESET, count_value);
        check("reset dac_code", COUNT_RESET, dac_code);
        check("reset drive", 16'h0001, {15'h0000, counter_drive});
        check("reset cmd_ready", 16'h0000, {15'h0000, cmd_ready});
        reset_n <= 1'b1;
        wait_step();
        check("count after reset", 16'h0001, count_value);
        $display("end of test mid reset");
        tally_and_finish();
    end
endmodule : tb_tracking_servo_counter_loop
